// *** hdl/aso_pkg.sv ***
// Package with operation codes, widths and reset values of the add and shift datapath.
package aso_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int DATA_W = 8;   // Data path width.
    localparam int PTR_W  = 16;  // Indirect pointer width.
    localparam int ADDR_W = 7;   // Register address field width.
    localparam int OFFS_W = 6;   // Signed pointer offset width.
    localparam int NREG   = 128; // Number of data registers.
    localparam int NPTR   = 2;   // Number of indirect pointers.

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  ACC_RST  = 8'h00;   // Accumulator after reset.
    localparam logic [7:0]  REG_RST  = 8'h00;   // Data registers after reset.
    localparam logic [15:0] PTR_RST  = 16'h0000; // Pointers after reset.
    localparam logic        FLAG_RST = 1'b0;    // Status flags after reset.

    // ****************************************************************
    // Flag bit positions in the result carry chain
    // ****************************************************************
    localparam int NIB_BIT = 4;  // Carry into bit 4 is the nibble carry.
    localparam int TOP_BIT = 7;  // Sign bit kept by the arithmetic shift.

    // ****************************************************************
    // Operation codes
    // ****************************************************************
    typedef enum logic [2:0] {
        OP_POINTER_ADD_LITERAL,
        OP_LITERAL_AND_TO_ACC,
        OP_LITERAL_ADD_TO_ACC,
        OP_ACC_AND_REG,
        OP_ACC_ADD_REG,
        OP_ACC_ADD_REG_WITH_CARRY,
        OP_ARITH_SHIFT_RIGHT_REG,
        OP_NONE
    } aso_op_t;

endpackage

// *** hdl/aso_adder.sv ***
// Eight-bit adder with carry in, giving nibble carry and carry out.
`timescale 1ns/1ps

module aso_adder
    import aso_pkg::*;
(
    input  wire logic [DATA_W-1:0] a,     // First operand.
    input  wire logic [DATA_W-1:0] b,     // Second operand.
    input  wire logic              cin,   // Carry into bit 0.
    output logic      [DATA_W-1:0] sum,   // Eight-bit sum.
    output logic                   nib_c, // Carry out of bit 3.
    output logic                   cout   // Carry out of bit 7.
);

    // ****************************************************************
    // Split addition
    // ****************************************************************
    wire logic [NIB_BIT:0]          low_sum;  // Low nibble plus its carry.
    wire logic [DATA_W-NIB_BIT:0]   high_sum; // High nibble plus its carry.

    // The low nibble is added first so its carry is seen as the nibble flag.
    assign low_sum  = {1'b0, a[NIB_BIT-1:0]} + {1'b0, b[NIB_BIT-1:0]}
                    + {{NIB_BIT{1'b0}}, cin};
    assign high_sum = {1'b0, a[DATA_W-1:NIB_BIT]} + {1'b0, b[DATA_W-1:NIB_BIT]}
                    + {{(DATA_W-NIB_BIT){1'b0}}, low_sum[NIB_BIT]};
    assign sum   = {high_sum[DATA_W-NIB_BIT-1:0], low_sum[NIB_BIT-1:0]};
    assign nib_c = low_sum[NIB_BIT];
    assign cout  = high_sum[DATA_W-NIB_BIT];

endmodule

// *** hdl/aso_alu.sv ***
// Add, AND and shift datapath slice with accumulator, registers, pointers and flags.
`timescale 1ns/1ps

// Summary of operation
// - Pointer adds sign-extended offset; flags untouched.
// - Pointer sum wraps within sixteen bits.
// - Literal AND into accumulator; zero flag only.
// - Literal add into accumulator; all three flags.
// - Accumulator AND register; zero flag only.
// - Destination bit picks accumulator or register.
// - Accumulator plus register; all three flags.
// - Add with carry; all three flags.
// - Shift right keeps sign, low bit to carry.
module aso_alu
    import aso_pkg::*;
(
    input  wire logic              SYS_CLK,     // Instruction clock.
    input  wire logic              SRST,        // Synchronous reset, active high.
    input  wire logic              EXEC,        // Execute the presented operation this cycle.
    input  wire aso_op_t           OP,          // Operation to execute.
    input  wire logic [DATA_W-1:0] LITERAL,     // Eight-bit immediate.
    input  wire logic [OFFS_W-1:0] PTR_OFFSET,  // Signed six-bit pointer offset.
    input  wire logic              PTR_SEL,     // Pointer 0 or 1.
    input  wire logic [ADDR_W-1:0] REG_ADDR,    // Data register address.
    input  wire logic              DEST,        // 0 accumulator, 1 register.
    input  wire logic [ADDR_W-1:0] RD_ADDR,     // Read port address.
    output logic      [DATA_W-1:0] RD_DATA,     // Data register at RD_ADDR.
    output logic      [DATA_W-1:0] ACC,         // Accumulator.
    output logic      [PTR_W-1:0]  PTR0,        // Indirect pointer 0.
    output logic      [PTR_W-1:0]  PTR1,        // Indirect pointer 1.
    output logic                   ARITH_OVERFLOW_BIT,  // Carry flag.
    output logic                   NIBBLE_OVERFLOW_BIT, // Digit carry flag.
    output logic                   RESULT_NULL_BIT      // Zero flag.
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [DATA_W-1:0] acc_q;                // Accumulator.
    logic [DATA_W-1:0] regs_q [NREG];        // Data registers.
    logic [PTR_W-1:0]  ptr_q  [NPTR];        // Indirect pointers.
    logic              c_q;                  // Carry flag.
    logic              dc_q;                 // Nibble carry flag.
    logic              z_q;                  // Zero flag.

    // ****************************************************************
    // Operand selection
    // ****************************************************************
    wire logic [DATA_W-1:0] reg_val;   // Addressed register value.
    wire logic              is_lit;    // Operation uses the literal.
    wire logic [DATA_W-1:0] operand_b; // Literal or register operand.
    wire logic              use_cin;   // Carry flag feeds the adder.
    wire logic [DATA_W-1:0] add_sum;   // Adder sum.
    wire logic              add_dc;    // Adder nibble carry.
    wire logic              add_c;     // Adder carry out.
    wire logic [DATA_W-1:0] and_res;   // AND result.
    wire logic [DATA_W-1:0] asr_res;   // Shift result.

    // Register file is read directly by index.
    assign reg_val   = regs_q[REG_ADDR];
    assign is_lit    = (OP == OP_LITERAL_AND_TO_ACC) || (OP == OP_LITERAL_ADD_TO_ACC);
    assign operand_b = is_lit ? LITERAL : reg_val;
    assign use_cin   = (OP == OP_ACC_ADD_REG_WITH_CARRY) ? c_q : 1'b0;
    assign and_res   = acc_q & operand_b;
    // The sign bit is copied so negative values stay negative.
    assign asr_res   = {reg_val[TOP_BIT], reg_val[DATA_W-1:1]};

    // Shared adder for all three add operations.
    aso_adder u_adder (
        .a     (acc_q),
        .b     (operand_b),
        .cin   (use_cin),
        .sum   (add_sum),
        .nib_c (add_dc),
        .cout  (add_c)
    );

    // ****************************************************************
    // Result and flag decode
    // ****************************************************************
    logic [DATA_W-1:0] result;     // Eight-bit result.
    logic              wr_acc;     // Result goes to the accumulator.
    logic              wr_reg;     // Result goes to the register.
    logic              upd_c;      // Carry flag is updated.
    logic              new_c;      // New carry value.
    logic              upd_dc;     // Nibble flag is updated.
    logic              upd_z;      // Zero flag is updated.
    logic              ptr_op;     // Pointer add is active.

    // Each operation chooses its result, its destination and its flags.
    always_comb begin
        result = add_sum;
        wr_acc = 1'b0;
        wr_reg = 1'b0;
        upd_c  = 1'b0;
        new_c  = add_c;
        upd_dc = 1'b0;
        upd_z  = 1'b0;
        ptr_op = 1'b0;
        case (OP)
            OP_POINTER_ADD_LITERAL: begin
                ptr_op = 1'b1;
            end
            OP_LITERAL_AND_TO_ACC: begin
                result = and_res;
                wr_acc = 1'b1;
                upd_z  = 1'b1;
            end
            OP_LITERAL_ADD_TO_ACC: begin
                wr_acc = 1'b1;
                upd_c  = 1'b1;
                upd_dc = 1'b1;
                upd_z  = 1'b1;
            end
            OP_ACC_AND_REG: begin
                result = and_res;
                wr_acc = ~DEST;
                wr_reg = DEST;
                upd_z  = 1'b1;
            end
            OP_ACC_ADD_REG, OP_ACC_ADD_REG_WITH_CARRY: begin
                wr_acc = ~DEST;
                wr_reg = DEST;
                upd_c  = 1'b1;
                upd_dc = 1'b1;
                upd_z  = 1'b1;
            end
            OP_ARITH_SHIFT_RIGHT_REG: begin
                result = asr_res;
                new_c  = reg_val[0];
                wr_acc = ~DEST;
                wr_reg = DEST;
                upd_c  = 1'b1;
                upd_z  = 1'b1;
            end
            default: begin
                result = add_sum;
            end
        endcase
    end

    // ****************************************************************
    // Pointer arithmetic
    // ****************************************************************
    wire logic [PTR_W-1:0] offs_ext; // Sign-extended offset.
    wire logic [PTR_W-1:0] ptr_sum;  // Wrapped pointer sum.

    // Two's complement addition wraps naturally at the sixteen-bit boundary.
    assign offs_ext = {{(PTR_W-OFFS_W){PTR_OFFSET[OFFS_W-1]}}, PTR_OFFSET};
    assign ptr_sum  = ptr_q[PTR_SEL] + offs_ext;

    // ****************************************************************
    // Commit
    // ****************************************************************
    // Accumulator and flags commit on the same edge as the result.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            acc_q <= ACC_RST;
            c_q   <= FLAG_RST;
            dc_q  <= FLAG_RST;
            z_q   <= FLAG_RST;
        end else if (EXEC) begin
            if (wr_acc) begin
                acc_q <= result;
            end
            if (upd_c) begin
                c_q <= new_c;
            end
            if (upd_dc) begin
                dc_q <= add_dc;
            end
            if (upd_z) begin
                z_q <= (result == 8'h00);
            end
        end
    end

    // Each data register is written back when addressed with destination one.
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            always_ff @(posedge SYS_CLK) begin
                if (SRST) begin
                    regs_q[gi] <= REG_RST;
                end else if (EXEC && wr_reg && (REG_ADDR == gi)) begin
                    regs_q[gi] <= result;
                end
            end
        end
        // Each pointer takes the wrapped sum when selected.
        for (gi = 0; gi < NPTR; gi++) begin : g_ptr
            always_ff @(posedge SYS_CLK) begin
                if (SRST) begin
                    ptr_q[gi] <= PTR_RST;
                end else if (EXEC && ptr_op && (PTR_SEL == gi)) begin
                    ptr_q[gi] <= ptr_sum;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign RD_DATA             = regs_q[RD_ADDR];
    assign ACC                 = acc_q;
    assign PTR0                = ptr_q[0];
    assign PTR1                = ptr_q[1];
    assign ARITH_OVERFLOW_BIT  = c_q;
    assign NIBBLE_OVERFLOW_BIT = dc_q;
    assign RESULT_NULL_BIT     = z_q;

endmodule

// *** sim/aso_alu_sva.sv ***
// Checker of the port behaviour of the add and shift datapath.
`timescale 1ns/1ps

module aso_alu_chk
    import aso_pkg::*;
(
    input wire logic              SYS_CLK,             // Instruction clock.
    input wire logic              SRST,                // Synchronous reset.
    input wire logic              EXEC,                // Execute strobe.
    input wire aso_op_t           OP,                  // Operation code.
    input wire logic [DATA_W-1:0] LITERAL,             // Immediate.
    input wire logic [OFFS_W-1:0] PTR_OFFSET,          // Signed pointer offset.
    input wire logic              PTR_SEL,             // Pointer select.
    input wire logic [ADDR_W-1:0] REG_ADDR,            // Operand address.
    input wire logic              DEST,                // Destination bit.
    input wire logic [ADDR_W-1:0] RD_ADDR,             // Peek address.
    input wire logic [DATA_W-1:0] RD_DATA,             // Peeked register.
    input wire logic [DATA_W-1:0] ACC,                 // Accumulator.
    input wire logic [PTR_W-1:0]  PTR0,                // Pointer 0.
    input wire logic [PTR_W-1:0]  PTR1,                // Pointer 1.
    input wire logic              ARITH_OVERFLOW_BIT,  // Carry flag.
    input wire logic              NIBBLE_OVERFLOW_BIT, // Nibble carry flag.
    input wire logic              RESULT_NULL_BIT      // Zero flag.
);
    // ****************************************************************
    // Assertions, all in the instruction clock domain
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);

    // Operand register is visible on the peek port in the issuing cycle.
    wire peek = RD_ADDR == REG_ADDR;

    a_idle_holds: assert property (!EXEC |=> $stable({ACC, PTR0, PTR1, ARITH_OVERFLOW_BIT,
        NIBBLE_OVERFLOW_BIT, RESULT_NULL_BIT})) else $error("state moved while idle");
    a_ptr_sum: assert property (EXEC && OP == OP_POINTER_ADD_LITERAL |=> ($past(PTR_SEL) ? PTR1 : PTR0)
        == ($past(PTR_SEL) ? $past(PTR1) : $past(PTR0)) + {{10{$past(PTR_OFFSET[5])}}, $past(PTR_OFFSET)})
        else $error("pointer sum wrong");
    a_ptr_flags: assert property (EXEC && OP == OP_POINTER_ADD_LITERAL |=> $stable({ACC,
        ARITH_OVERFLOW_BIT, NIBBLE_OVERFLOW_BIT, RESULT_NULL_BIT})) else $error("pointer add moved flags");
    a_lit_and: assert property (EXEC && OP == OP_LITERAL_AND_TO_ACC |=> ACC == $past(ACC & LITERAL)
        && $stable({ARITH_OVERFLOW_BIT, NIBBLE_OVERFLOW_BIT})) else $error("literal and wrong");
    a_lit_add: assert property (EXEC && OP == OP_LITERAL_ADD_TO_ACC |=> {ARITH_OVERFLOW_BIT, ACC}
        == $past(ACC) + $past(LITERAL) && NIBBLE_OVERFLOW_BIT
        == ($past(ACC[3:0]) + $past(LITERAL[3:0]) > 5'h0F)) else $error("literal add wrong");
    a_and_reg: assert property (EXEC && OP == OP_ACC_AND_REG && !DEST && peek
        |=> ACC == $past(ACC & RD_DATA)) else $error("register and wrong");
    a_add_reg: assert property (EXEC && OP == OP_ACC_ADD_REG && DEST && peek |=> $stable(ACC)
        && (!$stable(RD_ADDR) || {ARITH_OVERFLOW_BIT, RD_DATA} == $past(ACC) + $past(RD_DATA)))
        else $error("register add wrong");
    a_carry_add: assert property (EXEC && OP == OP_ACC_ADD_REG_WITH_CARRY && !DEST && peek
        |=> {ARITH_OVERFLOW_BIT, ACC} == $past(ACC) + $past(RD_DATA) + $past(ARITH_OVERFLOW_BIT))
        else $error("add with carry wrong");
    a_shift_sign: assert property (EXEC && OP == OP_ARITH_SHIFT_RIGHT_REG && !DEST && peek
        |=> ACC == {$past(RD_DATA[7]), $past(RD_DATA[7:1])} && ARITH_OVERFLOW_BIT == $past(RD_DATA[0])
        && $stable(NIBBLE_OVERFLOW_BIT)) else $error("shift wrong");
    a_zero_flag: assert property (EXEC && !DEST && OP != OP_POINTER_ADD_LITERAL && OP != OP_NONE
        |=> RESULT_NULL_BIT == (ACC == 8'h00)) else $error("zero flag wrong");
endmodule

bind aso_alu aso_alu_chk i_chk (.SYS_CLK, .SRST, .EXEC, .OP, .LITERAL, .PTR_OFFSET, .PTR_SEL,
    .REG_ADDR, .DEST, .RD_ADDR, .RD_DATA, .ACC, .PTR0, .PTR1, .ARITH_OVERFLOW_BIT,
    .NIBBLE_OVERFLOW_BIT, .RESULT_NULL_BIT);

// *** sim/aso_alu_tb.sv ***
// Self-checking bench of the add and shift datapath.
`timescale 1ns/1ps

module aso_alu_tb
    import aso_pkg::*;
;
    // ****************************************************************
    // Signals
    // ****************************************************************
    typedef struct packed {
        aso_op_t op; logic [7:0] k; logic d; logic [6:0] a;
        logic [7:0] acc; logic [2:0] f; logic [7:0] rd; logic [15:0] p;
    } aso_row_t;                  // Inputs, then expected state after the edge.
    logic       SYS_CLK = 1'b0;   // Clock.
    logic       SRST    = 1'b1;   // Reset held at start.
    logic       EXEC    = 1'b0;   // Execute strobe.
    aso_op_t    OP      = OP_NONE; // Operation.
    logic [7:0] LITERAL = 8'h00;  // Immediate.
    logic [5:0] PTR_OFFSET = 6'h00; // Pointer offset.
    logic       PTR_SEL = 1'b0;   // Pointer select.
    logic       DEST    = 1'b0;   // Destination bit.
    logic [6:0] REG_ADDR = 7'h00; // Operand address.
    logic [6:0] RD_ADDR = 7'h00;  // Peek address.
    logic [7:0] RD_DATA, ACC;     // Observed data.
    logic [15:0] PTR0, PTR1;      // Observed pointers.
    logic       ARITH_OVERFLOW_BIT, NIBBLE_OVERFLOW_BIT, RESULT_NULL_BIT; // Observed flags.
    int         errors = 0;       // Mismatches.
    int         num_checks = 0;   // Comparisons.
    int         cyc = 0;          // Cycle count for the hang guard.
    aso_row_t   rows[$];          // Ordinary cases.

    aso_alu i_dut (.SYS_CLK, .SRST, .EXEC, .OP, .LITERAL, .PTR_OFFSET, .PTR_SEL, .REG_ADDR,
        .DEST, .RD_ADDR, .RD_DATA, .ACC, .PTR0, .PTR1, .ARITH_OVERFLOW_BIT,
        .NIBBLE_OVERFLOW_BIT, .RESULT_NULL_BIT);

    // Clock of 25 ns period.
    initial begin
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Builds one row.
    function automatic aso_row_t mk(aso_op_t o, logic [7:0] k, logic d, logic [6:0] a,
        logic [7:0] acc, logic [2:0] f, logic [7:0] rd, logic [15:0] p);
        return '{o, k, d, a, acc, f, rd, p};
    endfunction

    // Compares one value and counts it.
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // Presents a row at a falling edge and checks the state one cycle later.
    task automatic run(input aso_row_t r, input logic e);
        OP = r.op;
        LITERAL = r.k;
        PTR_OFFSET = r.k[5:0];
        PTR_SEL = r.d;
        DEST = r.d;
        REG_ADDR = r.a;
        RD_ADDR = r.a;
        EXEC = e;
        @(negedge SYS_CLK);
        chk("acc", {8'h00, r.acc}, {8'h00, ACC});
        chk("flags", {13'h0, r.f}, {13'h0, ARITH_OVERFLOW_BIT, NIBBLE_OVERFLOW_BIT, RESULT_NULL_BIT});
        chk("reg", {8'h00, r.rd}, {8'h00, RD_DATA});
        chk("ptr", r.p, r.d ? PTR1 : PTR0);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Hang guard: the run needs well under 200 cycles.
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 200) begin
            errors++;
            finish_test();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rows.push_back(mk(OP_LITERAL_ADD_TO_ACC, 8'hF1, 0, 5, 8'hF1, 3'h0, 8'h00, 16'h0000));
        rows.push_back(mk(OP_LITERAL_ADD_TO_ACC, 8'h0F, 0, 5, 8'h00, 3'h7, 8'h00, 16'h0000));
        rows.push_back(mk(OP_LITERAL_AND_TO_ACC, 8'hFF, 0, 5, 8'h00, 3'h7, 8'h00, 16'h0000));
        rows.push_back(mk(OP_LITERAL_ADD_TO_ACC, 8'h88, 0, 5, 8'h88, 3'h0, 8'h00, 16'h0000));
        rows.push_back(mk(OP_ACC_ADD_REG, 8'h00, 1, 5, 8'h88, 3'h0, 8'h88, 16'h0000));
        rows.push_back(mk(OP_ACC_ADD_REG, 8'h00, 1, 5, 8'h88, 3'h6, 8'h10, 16'h0000));
        rows.push_back(mk(OP_ACC_ADD_REG_WITH_CARRY, 8'h00, 0, 5, 8'h99, 3'h0, 8'h10, 16'h0000));
        rows.push_back(mk(OP_ACC_ADD_REG, 8'h00, 1, 6, 8'h99, 3'h0, 8'h99, 16'h0000));
        rows.push_back(mk(OP_ARITH_SHIFT_RIGHT_REG, 8'h00, 1, 6, 8'h99, 3'h4, 8'hCC, 16'h0000));
        rows.push_back(mk(OP_LITERAL_AND_TO_ACC, 8'h00, 0, 6, 8'h00, 3'h5, 8'hCC, 16'h0000));
        rows.push_back(mk(OP_ARITH_SHIFT_RIGHT_REG, 8'h00, 0, 6, 8'hE6, 3'h0, 8'hCC, 16'h0000));
        rows.push_back(mk(OP_ACC_AND_REG, 8'h00, 1, 6, 8'hE6, 3'h0, 8'hC4, 16'h0000));
        rows.push_back(mk(OP_ACC_AND_REG, 8'h00, 0, 7, 8'h00, 3'h1, 8'h00, 16'h0000));
        rows.push_back(mk(OP_POINTER_ADD_LITERAL, 8'h3F, 0, 7, 8'h00, 3'h1, 8'h00, 16'hFFFF));
        rows.push_back(mk(OP_POINTER_ADD_LITERAL, 8'h1F, 1, 7, 8'h00, 3'h1, 8'h00, 16'h001F));
        rows.push_back(mk(OP_POINTER_ADD_LITERAL, 8'h01, 0, 7, 8'h00, 3'h1, 8'h00, 16'h0000));
        rows.push_back(mk(OP_POINTER_ADD_LITERAL, 8'h20, 1, 7, 8'h00, 3'h1, 8'h00, 16'hFFFF));
        rows.push_back(mk(OP_NONE, 8'hFF, 1, 6, 8'h00, 3'h1, 8'hC4, 16'hFFFF));
        repeat (10) @(negedge SYS_CLK);
        SRST = 1'b0;
        foreach (rows[i]) run(rows[i], 1'b1);
        $display("test rows done");
        run(mk(OP_POINTER_ADD_LITERAL, 8'h01, 1, 6, 8'h00, 3'h1, 8'hC4, 16'hFFFF), 1'b0);
        $display("test idle done");
        SRST = 1'b1;
        run(mk(OP_NONE, 8'h00, 1, 6, 8'h00, 3'h0, 8'h00, 16'h0000), 1'b0);
        SRST = 1'b0;
        run(mk(OP_NONE, 8'h00, 0, 5, 8'h00, 3'h0, 8'h00, 16'h0000), 1'b0);
        $display("test reset done");
        run(mk(OP_LITERAL_ADD_TO_ACC, 8'hF0, 0, 7, 8'hF0, 3'h0, 8'h00, 16'h0000), 1'b1);
        run(mk(OP_LITERAL_ADD_TO_ACC, 8'h1F, 0, 7, 8'h0F, 3'h4, 8'h00, 16'h0000), 1'b1);
        run(mk(OP_ACC_ADD_REG_WITH_CARRY, 8'h00, 1, 7, 8'h0F, 3'h2, 8'h10, 16'h0000), 1'b1);
        EXEC = 1'b0;
        $display("test carry in done");
        finish_test();
    end
endmodule
